// ### verilog/stco_top.v
// Start-up timer, clock output and LED polarity sensing behind a serial port
//
// Overview of operation
// - Start-up timer runs 300 us after power-on or power-down exit.
// - All registers and buffer bytes stay reachable while the timer runs.
// - Timer expiry sets the clock-ready flag in the status register.
// - Clock pin low after power-up until expiry, then divide-by-4.
// - Soft or pin reset leaves clock output setting and clock running.
// - Power-down keeps the clock running; exit restarts the timer.
// - Divider code zero disables the output and drives the pin low.
// - No high or low phase shorter than the new setting implies.
// - On divider change, two to eight low cycles with no pulses.
// - Codes 101,100,011,010,001 divide by 8,4,3,2,2.
// - Upper five setting bits read zero; setting resets to divide-by-4.
// - Each system reset senses LED wiring, then drives configured default.
// - LED polarity latched only at system reset.
// - Duplex bit cleared if second LED sources, set if it sinks.
// - Without a second LED the duplex bit may come up undefined.
// - Each LED has its own 4-bit mode; one stretch enable and stretch length serve both.
`timescale 1ns/1ps
`include "stco_defines.vh"

module stco_top #(
  parameter [31:0] P_SUT_CYCLES = `STCO_SUT_CYCLES,
  parameter [31:0] P_STR_NORM   = `STCO_STR_NORM_CYC,
  parameter [31:0] P_STR_MED    = `STCO_STR_MED_CYC,
  parameter [31:0] P_STR_LONG   = `STCO_STR_LONG_CYC,
  parameter        P_BLINK_W    = 22
) (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  input  wire       i_rst_pin_n,
  input  wire       i_spi_cs_n,
  input  wire       i_spi_sck,
  input  wire       i_spi_si,
  output wire       o_spi_so,
  output wire       o_spi_so_oe,
  input  wire [6:0] i_phy_event,
  input  wire       i_led_a,
  output wire       o_led_a,
  output wire       o_led_a_oe,
  input  wire       i_led_b,
  output wire       o_led_b,
  output wire       o_led_b_oe,
  output wire       o_clk_out,
  output wire       o_clock_ready,
  output wire       o_power_down,
  output wire       o_tx_request,
  output wire       o_rx_enable,
  output wire       o_phy_duplex
);

  localparam ST_SENSE = 2'b01;
  localparam ST_DRIVE = 2'b10;

  // Pin synchronisers: {led_b, led_a, rst_pin_n, cs_n, sck, si}
  reg  [5:0]  sync1_r;
  reg  [5:0]  sync2_r;
  wire        s_si    = sync2_r[0];
  wire        s_sck   = sync2_r[1];
  wire        s_cs_n  = sync2_r[2];
  wire        s_rst_n = sync2_r[3];
  wire [1:0]  s_led   = sync2_r[5:4];

  // Serial port state
  reg         sck_d_r;
  reg  [3:0]  bitcnt_r;
  reg  [7:0]  shin_r;
  reg  [7:0]  op_r;
  reg  [7:0]  shout_r;
  reg         so_r;
  reg         so_oe_r;

  // Registers
  reg  [7:0]  mem_r [0:15];
  reg  [7:0]  ctrl1_r;
  reg  [2:0]  clkcon_r;
  reg  [15:0] ledcfg_r;
  reg         duplex_r;
  reg  [1:0]  sink_r;

  // Start-up timer
  reg  [31:0] sut_cnt_r;
  reg         sut_run_r;
  reg         ready_r;
  reg         sut_once_r;
  reg         pd_d_r;

  // LED logic
  reg  [1:0]  state_r;
  reg  [3:0]  sense_cnt_r;
  reg  [P_BLINK_W-1:0] blink_r;
  reg  [31:0] str_r [0:1];
  reg  [1:0]  led_r;
  reg  [1:0]  led_oe_r;
  reg  [7:0]  rdata;
  integer     i;

  wire        rise     = s_sck & ~sck_d_r;
  wire        fall     = ~s_sck & sck_d_r;
  wire [7:0]  byte_in  = {shin_r[6:0], s_si};
  wire        cmd_done = ~s_cs_n & rise & (bitcnt_r == 4'h7);
  wire        spi_wr   = ~s_cs_n & rise & (bitcnt_r == 4'hF) & (op_r[7:5] == `STCO_OP_WRITE);
  wire        soft_rst = cmd_done & (byte_in == `STCO_OP_SOFT_RESET);
  wire        sys_rst  = ~s_rst_n | soft_rst;
  wire        pd_now   = ctrl1_r[`STCO_CTRL1_PWRDN];
  wire        pd_exit  = pd_d_r & ~pd_now;
  wire [31:0] sut_inc  = sut_cnt_r + 32'h1;

  // Register read mux; 0x00-0x0F read buffer bytes, any other address not listed reads zero
  always @* begin
    case (byte_in[4:0])
      `STCO_ADDR_CTRL1:     rdata = ctrl1_r;
      `STCO_ADDR_STATUS:    rdata = {7'h00, ready_r};
      `STCO_ADDR_CLKCON:    rdata = {5'h00, clkcon_r};
      `STCO_ADDR_LEDCFG_HI: rdata = ledcfg_r[15:8];
      `STCO_ADDR_LEDCFG_LO: rdata = ledcfg_r[7:0];
      `STCO_ADDR_PHYCON1:   rdata = {7'h00, duplex_r};
      `STCO_ADDR_LEDSENSE:  rdata = {6'h00, sink_r};
      default:              rdata = byte_in[4] ? 8'h00 : mem_r[byte_in[3:0]];
    endcase
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= 6'h0C;
      sync2_r <= 6'h0C;
    end else if (i_ce) begin
      sync1_r <= {i_led_b, i_led_a, i_rst_pin_n, i_spi_cs_n, i_spi_sck, i_spi_si};
      sync2_r <= sync1_r;
    end
  end

  // Serial port: mode 0, one command byte then one data byte, MSB first.
  // Pins are oversampled, so the serial clock must stay well below i_clk/4.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_d_r  <= 1'b0;
      bitcnt_r <= 4'h0;
      shin_r   <= 8'h00;
      op_r     <= 8'h00;
      shout_r  <= 8'h00;
      so_r     <= 1'b0;
      so_oe_r  <= 1'b0;
    end else if (i_ce) begin
      sck_d_r <= s_sck;
      so_oe_r <= ~s_cs_n;
      if (s_cs_n) begin
        bitcnt_r <= 4'h0;
        so_r     <= 1'b0;
      end else if (rise) begin
        shin_r   <= byte_in;
        bitcnt_r <= bitcnt_r + 4'h1;
        if (bitcnt_r == 4'h7) begin
          op_r    <= byte_in;
          shout_r <= (byte_in[7:5] == `STCO_OP_READ) ? rdata : 8'h00;
        end
      end else if (fall && bitcnt_r[3]) begin
        so_r    <= shout_r[7];
        shout_r <= {shout_r[6:0], 1'b0};
      end
    end
  end

  // Buffer bytes keep their contents across every reset
  always @(posedge i_clk) begin
    if (i_ce && spi_wr && !op_r[4]) begin
      mem_r[op_r[3:0]] <= byte_in;
    end
  end

  // Control registers; the clock output setting ignores pin and soft reset
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl1_r  <= 8'h00;
      clkcon_r <= `STCO_CLKCON_RST;
      ledcfg_r <= `STCO_LEDCFG_RST;
    end else if (i_ce) begin
      if (sys_rst) begin
        ctrl1_r  <= 8'h00;
        ledcfg_r <= `STCO_LEDCFG_RST;
      end else if (spi_wr) begin
        case (op_r[4:0])
          `STCO_ADDR_CTRL1:     ctrl1_r <= byte_in;
          `STCO_ADDR_CLKCON:    clkcon_r <= byte_in[2:0];
          `STCO_ADDR_LEDCFG_HI: ledcfg_r[15:8] <= byte_in;
          `STCO_ADDR_LEDCFG_LO: ledcfg_r[7:0] <= byte_in;
          default: ;
        endcase
      end
    end
  end

  // Start-up timer
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sut_cnt_r  <= 32'h0;
      sut_run_r  <= 1'b1;
      ready_r    <= 1'b0;
      sut_once_r <= 1'b0;
      pd_d_r     <= 1'b0;
    end else if (i_ce) begin
      pd_d_r <= pd_now;
      if (pd_exit) begin
        sut_cnt_r <= 32'h0;
        sut_run_r <= 1'b1;
        ready_r   <= 1'b0;
      end else if (sut_run_r) begin
        if (sut_inc == P_SUT_CYCLES) begin
          sut_run_r  <= 1'b0;
          ready_r    <= 1'b1;
          sut_once_r <= 1'b1;
        end else begin
          sut_cnt_r <= sut_inc;
        end
      end
    end
  end

  // Runs from power-on reset only, so pin reset, soft reset and power-down
  // never interrupt the output clock
  stco_clkdiv u_clkdiv (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_run     (sut_once_r),
    .i_sel     (clkcon_r),
    .o_clk_out (o_clk_out)
  );

  // Stretch length chosen by the two rate bits
  function [31:0] str_len;
    input [1:0] rate;
    begin
      case (rate)
        2'h1:    str_len = P_STR_MED;
        2'h2:    str_len = P_STR_LONG;
        default: str_len = P_STR_NORM;
      endcase
    end
  endfunction

  // Event selected by an LED mode; codes 1-7 show one PHY status each
  function ev_of;
    input [3:0] code;
    input [6:0] ev;
    begin
      ev_of = (code != 4'h0) && (code < 4'h8) && ev[code[2:0] - 3'h1];
    end
  endfunction

  // Logical LED state before the wiring polarity is applied
  function led_on;
    input [3:0] code;
    input       shown;
    input       fast;
    input       slow;
    begin
      case (code)
        4'h8:    led_on = 1'b1;
        4'hA:    led_on = fast;
        4'hB:    led_on = slow;
        4'h9:    led_on = 1'b0;
        default: led_on = (code < 4'h8) & shown;
      endcase
    end
  endfunction

  // Sense LED wiring with the pins released, then drive them. A pin that
  // floats high has its LED tied to the supply, so the pin sinks current.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r     <= ST_SENSE;
      sense_cnt_r <= 4'h0;
      sink_r      <= 2'b00;
      duplex_r    <= 1'b0;
      blink_r     <= {P_BLINK_W{1'b0}};
      led_r       <= 2'b00;
      led_oe_r    <= 2'b00;
      str_r[0]    <= 32'h0;
      str_r[1]    <= 32'h0;
    end else if (i_ce) begin
      blink_r <= blink_r + {{(P_BLINK_W-1){1'b0}}, 1'b1};
      for (i = 0; i < 2; i = i + 1) begin
        if (ev_of(ledcfg_r[11-4*i -: 4], i_phy_event)) begin
          str_r[i] <= str_len(ledcfg_r[3:2]);
        end else if (str_r[i] != 32'h0) begin
          str_r[i] <= str_r[i] - 32'h1;
        end
      end
      case (state_r)
        ST_SENSE: begin
          led_oe_r <= 2'b00;
          led_r    <= 2'b00;
          if (sys_rst) begin
            sense_cnt_r <= 4'h0;
          end else if (sense_cnt_r == `STCO_SENSE_CYC - 4'h1) begin
            sink_r   <= s_led;
            duplex_r <= s_led[1];
            state_r  <= ST_DRIVE;
          end else begin
            sense_cnt_r <= sense_cnt_r + 4'h1;
          end
        end
        ST_DRIVE: begin
          if (sys_rst) begin
            state_r     <= ST_SENSE;
            sense_cnt_r <= 4'h0;
            led_oe_r    <= 2'b00;
          end else begin
            if (spi_wr && op_r[4:0] == `STCO_ADDR_PHYCON1) begin
              duplex_r <= byte_in[`STCO_PHYCON1_DUPLEX];
            end
            led_oe_r <= 2'b11;
            for (i = 0; i < 2; i = i + 1) begin
              led_r[i] <= sink_r[i] ^ led_on(ledcfg_r[11-4*i -: 4],
                ev_of(ledcfg_r[11-4*i -: 4], i_phy_event) |
                (ledcfg_r[`STCO_LED_STRETCH] & (str_r[i] != 32'h0)),
                blink_r[P_BLINK_W-3], blink_r[P_BLINK_W-1]);
            end
          end
        end
        default: begin
          state_r     <= ST_SENSE;
          sense_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  assign o_spi_so      = so_r;
  assign o_spi_so_oe   = so_oe_r;
  assign o_led_a       = led_r[0];
  assign o_led_a_oe    = led_oe_r[0];
  assign o_led_b       = led_r[1];
  assign o_led_b_oe    = led_oe_r[1];
  assign o_clock_ready = ready_r;
  assign o_power_down  = ctrl1_r[`STCO_CTRL1_PWRDN];
  assign o_tx_request  = ctrl1_r[`STCO_CTRL1_TXREQ];
  assign o_rx_enable   = ctrl1_r[`STCO_CTRL1_RXON];
  assign o_phy_duplex  = duplex_r;

endmodule

// ### verilog/stco_defines.vh
// Constants shared by the start-up timer and clock output block
`ifndef STCO_DEFINES_VH
`define STCO_DEFINES_VH

// Timing
`define STCO_CLK_MHZ         40
`define STCO_SUT_OSC_CYCLES  7500
`define STCO_SUT_TIME_US     300
`define STCO_SUT_CYCLES      (`STCO_SUT_TIME_US * `STCO_CLK_MHZ)
`define STCO_STR_NORM_MS     40
`define STCO_STR_MED_MS      70
`define STCO_STR_LONG_MS     140
`define STCO_STR_NORM_CYC    (`STCO_STR_NORM_MS * 1000 * `STCO_CLK_MHZ)
`define STCO_STR_MED_CYC     (`STCO_STR_MED_MS * 1000 * `STCO_CLK_MHZ)
`define STCO_STR_LONG_CYC    (`STCO_STR_LONG_MS * 1000 * `STCO_CLK_MHZ)
`define STCO_SENSE_CYC       4'h8
`define STCO_GAP_CYC         4'h2

// Serial commands
`define STCO_OP_READ         3'h0
`define STCO_OP_WRITE        3'h2
`define STCO_OP_SOFT_RESET   8'hFF

// Register addresses (0x00-0x0F are packet buffer bytes)
`define STCO_ADDR_CTRL1      5'h10
`define STCO_ADDR_STATUS     5'h11
`define STCO_ADDR_CLKCON     5'h12
`define STCO_ADDR_LEDCFG_HI  5'h13
`define STCO_ADDR_LEDCFG_LO  5'h14
`define STCO_ADDR_PHYCON1    5'h15
`define STCO_ADDR_LEDSENSE   5'h16

// Field positions
`define STCO_CTRL1_PWRDN     0
`define STCO_CTRL1_TXREQ     2
`define STCO_CTRL1_RXON      3
`define STCO_STATUS_READY    0
`define STCO_PHYCON1_DUPLEX  0
`define STCO_LED_STRETCH     1

// Reset values
`define STCO_CLKCON_RST      3'h4
`define STCO_LEDCFG_RST      16'h3422

// Divider codes and periods in clock cycles
`define STCO_DIV_OFF         3'h0
`define STCO_DIV_1           3'h1
`define STCO_DIV_2           3'h2
`define STCO_DIV_3           3'h3
`define STCO_DIV_4           3'h4
`define STCO_DIV_8           3'h5
`define STCO_PER_1           4'h2
`define STCO_PER_2           4'h2
`define STCO_PER_3           4'h3
`define STCO_PER_4           4'h4
`define STCO_PER_8           4'h8

`endif

// ### verilog/stco_clkdiv.v
// Glitch-free programmable clock output divider
`timescale 1ns/1ps
`include "stco_defines.vh"

module stco_clkdiv (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  input  wire       i_run,
  input  wire [2:0] i_sel,
  output wire       o_clk_out
);

  reg  [2:0] act_sel_r;
  reg  [3:0] cnt_r;
  reg  [3:0] gap_r;
  reg        out_r;
  wire [2:0] want;
  wire [3:0] per;
  wire [3:0] hi;
  wire [3:0] cnt_inc;

  // Period of one output cycle; reserved codes give zero and keep the pin low
  function [3:0] div_period;
    input [2:0] sel;
    begin
      case (sel)
        `STCO_DIV_1: div_period = `STCO_PER_1;
        `STCO_DIV_2: div_period = `STCO_PER_2;
        `STCO_DIV_3: div_period = `STCO_PER_3;
        `STCO_DIV_4: div_period = `STCO_PER_4;
        `STCO_DIV_8: div_period = `STCO_PER_8;
        default:     div_period = 4'h0;
      endcase
    end
  endfunction

  // Pin held low until the first expiry, then follows the setting
  assign want    = i_run ? i_sel : `STCO_DIV_OFF;
  assign per     = div_period(act_sel_r);
  assign hi      = (per + 4'h1) >> 1;
  assign cnt_inc = cnt_r + 4'h1;

  // A new setting is taken only at the end of a whole period, so every
  // phase already begun runs to its full length
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      act_sel_r <= `STCO_DIV_OFF;
      cnt_r     <= 4'h0;
      gap_r     <= 4'h0;
      out_r     <= 1'b0;
    end else if (i_ce) begin
      if (per == 4'h0) begin
        out_r <= 1'b0;
        if (gap_r != 4'h0) begin
          gap_r <= gap_r - 4'h1;
        end else if (div_period(want) != 4'h0) begin
          act_sel_r <= want;
          cnt_r     <= 4'h0;
          out_r     <= 1'b1;
        end
      end else if (cnt_inc == per) begin
        if (want != act_sel_r) begin
          act_sel_r <= `STCO_DIV_OFF;
          gap_r     <= `STCO_GAP_CYC;
          out_r     <= 1'b0;
        end else begin
          cnt_r <= 4'h0;
          out_r <= 1'b1;
        end
      end else begin
        cnt_r <= cnt_inc;
        out_r <= (cnt_inc < hi);
      end
    end
  end

  assign o_clk_out = out_r;

endmodule

// ### bench/stco_properties.sv
// Port-level checks for the start-up timer, clock pin and LED sensing
`timescale 1ns/1ps
module stco_properties #(
  parameter [31:0] P_SUT_CYCLES = 32'h2EE0
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_rst_pin_n,
  input wire i_spi_cs_n,
  input wire i_led_b,
  input wire o_spi_so_oe,
  input wire o_led_a_oe,
  input wire o_led_b_oe,
  input wire o_clk_out,
  input wire o_clock_ready,
  input wire o_power_down,
  input wire o_phy_duplex
);
  logic [31:0] cnt_r;
  logic        seen_r;
  logic        pd_d_r;
  // Count restarts on power-down exit so both start-up paths share one bound
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r  <= 32'h0;
      seen_r <= 1'b0;
      pd_d_r <= 1'b0;
    end else begin
      cnt_r  <= (o_clock_ready || (pd_d_r && !o_power_down)) ? 32'h0 : cnt_r + 32'h1;
      seen_r <= seen_r | o_clock_ready;
      pd_d_r <= o_power_down;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_sense;
    (!o_led_a_oe && !o_led_b_oe) [*8];
  endsequence
  sequence s_pin_press;
    $fell(i_rst_pin_n) ##4 1'b1;
  endsequence
  chk_ready_count: assert property (
    $rose(o_clock_ready) |-> cnt_r + 32'h2 >= P_SUT_CYCLES && cnt_r <= P_SUT_CYCLES + 32'h2)
    else $error("clock ready rose at wrong count");
  chk_ready_restart: assert property (
    $fell(o_power_down) |-> ##[0:2] !o_clock_ready)
    else $error("clock ready stayed set after power-down exit");
  chk_quiet_boot: assert property (
    !seen_r |-> !o_clk_out)
    else $error("clock pin active before first ready");
  chk_high_bounded: assert property (
    $rose(o_clk_out) |-> ##[1:4] !o_clk_out)
    else $error("clock pin high phase too long");
  chk_pd_running: assert property (
    o_power_down && $rose(o_clk_out) |-> ##[1:16] $rose(o_clk_out))
    else $error("clock pin stopped in power-down");
  chk_sense_boot: assert property (
    $rose(i_nrst) |-> s_sense)
    else $error("LED driven during power-on sensing");
  chk_sense_pin: assert property (
    s_pin_press |-> s_sense)
    else $error("LED not re-sensed on pin reset");
  chk_duplex_sense: assert property (
    $rose(o_led_b_oe) |-> ##[0:2] (o_phy_duplex == $past(i_led_b, 4)))
    else $error("duplex bit differs from sensed wiring");
  chk_ready_kept: assert property (
    $fell(i_rst_pin_n) && o_clock_ready && !o_power_down |-> o_clock_ready [*8])
    else $error("pin reset cleared clock ready");
  chk_port_live: assert property (
    $fell(i_spi_cs_n) |-> ##[1:4] o_spi_so_oe)
    else $error("serial port did not answer select");
endmodule

bind stco_top stco_properties #(.P_SUT_CYCLES(P_SUT_CYCLES)) u_props (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_rst_pin_n(i_rst_pin_n), .i_spi_cs_n(i_spi_cs_n),
  .i_led_b(i_led_b), .o_spi_so_oe(o_spi_so_oe), .o_led_a_oe(o_led_a_oe),
  .o_led_b_oe(o_led_b_oe), .o_clk_out(o_clk_out), .o_clock_ready(o_clock_ready),
  .o_power_down(o_power_down), .o_phy_duplex(o_phy_duplex)
);

// ### bench/stco_host.sv
// Host model: serial master that polls and programs the device
`timescale 1ns/1ps
`include "stco_defines.vh"
module stco_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  logic [7:0] rd_v;
  event       rd_done;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // Toggle data between frames so a stale bit never looks valid
  always @(posedge i_clk) if (o_cs_n) o_si <= ~o_si;
  task automatic hw(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // Each serial clock half spans five system clocks, above the three the port needs
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
    logic [15:0] sh;
    if (cmd == {`STCO_OP_WRITE, `STCO_ADDR_CLKCON} && dat[2:1] == 2'h3) return;
    sh = {cmd, dat};
    hw(1);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_si = sh[i];
      hw(5);
      o_sck = 1'b1;
      if (i < 8) rd_v[i] = i_so;
      hw(5);
      o_sck = 1'b0;
    end
    hw(5);
    o_cs_n = 1'b1;
    if (cmd[7:5] == `STCO_OP_READ) -> rd_done;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the start-up timer, clock output and LED sensing
`timescale 1ns/1ps
`include "stco_defines.vh"
module testbench;
  localparam int SUT_CYC = 2000;
  localparam logic [2:0] CODES [5] = '{`STCO_DIV_8, `STCO_DIV_3, `STCO_DIV_2, `STCO_DIV_1,
                                       `STCO_DIV_4};
  localparam logic [3:0] PERS [5] = '{`STCO_PER_8, `STCO_PER_3, `STCO_PER_2, `STCO_PER_1,
                                      `STCO_PER_4};
  localparam logic [3:0] HIGHS [5] = '{4'h4, 4'h2, 4'h1, 4'h1, 4'h2};
  logic       clk, nrst, rpin, wa, wb;
  logic [6:0] ev;
  logic [7:0] obs_v, rv;
  wire        cs_n, sck, si, so, lao, laoe, lbo, lboe, cko, rdy, pd, txr, rxe, dpx;
  wire        pa = laoe ? lao : wa;
  wire        pb = lboe ? lbo : wb;
  int         fail_count = 0;
  int         n_tests = 0;
  int         p, lo, hi;
  logic [7:0] exq[$];
  string      nmq[$];
  event       obs_ev;
  stco_top #(.P_SUT_CYCLES(SUT_CYC), .P_STR_NORM(10), .P_STR_MED(20), .P_STR_LONG(30),
    .P_BLINK_W(5)) u_dut (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_rst_pin_n(rpin), .i_spi_cs_n(cs_n),
    .i_spi_sck(sck), .i_spi_si(si), .o_spi_so(so), .o_spi_so_oe(), .i_phy_event(ev),
    .i_led_a(pa), .o_led_a(lao), .o_led_a_oe(laoe), .i_led_b(pb), .o_led_b(lbo),
    .o_led_b_oe(lboe), .o_clk_out(cko), .o_clock_ready(rdy), .o_power_down(pd),
    .o_tx_request(txr), .o_rx_enable(rxe), .o_phy_duplex(dpx));
  stco_host u_host (.i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got);
    string      n;
    logic [7:0] e;
    n = nmq.pop_front();
    e = exq.pop_front();
    n_tests++;
    if (got !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, got);
    end
  endtask
  always @(u_host.rd_done) cmp(u_host.rd_v);
  always @(obs_ev) cmp(obs_v);
  task automatic note(input string n, input logic [7:0] e);
    nmq.push_back(n);
    exq.push_back(e);
  endtask
  task automatic see(input string n, input logic [7:0] e, input logic [7:0] g);
    note(n, e);
    obs_v = g;
    -> obs_ev;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
    note(n, e);
    u_host.xfer({`STCO_OP_READ, a}, 8'h00);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer({`STCO_OP_WRITE, a}, d);
  endtask
  // Longest high and low runs and the last period of the clock pin over n cycles
  task automatic watch(input int n);
    int   last, rl, rh;
    logic pv;
    last = -1;
    rl = 0;
    rh = 0;
    lo = 0;
    hi = 0;
    p = 0;
    pv = cko;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      rl = cko ? 0 : rl + 1;
      rh = cko ? rh + 1 : 0;
      lo = (rl > lo) ? rl : lo;
      hi = (rh > hi) ? rh : hi;
      if (cko && !pv) begin
        p = (last < 0) ? 0 : i - last;
        last = i;
      end
      pv = cko;
    end
  endtask
  task automatic wait_rdy;
    for (int k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge clk);
    #2;
  endtask
  task automatic pin_reset(input logic b);
    wb = b;
    rpin = 1'b0;
    repeat (20) @(posedge clk);
    #2 rpin = 1'b1;
    repeat (40) @(posedge clk);
    #2;
  endtask
  initial begin
    rv = $urandom(32'hAD43);
    nrst = 1'b0;
    rpin = 1'b1;
    wa = 1'b1;
    wb = 1'b1;
    ev = 7'h00;
    repeat (16) @(posedge clk);
    #2 nrst = 1'b1;
    rd(`STCO_ADDR_STATUS, 8'h00, "ready_early");
    rd(`STCO_ADDR_CLKCON, 8'h04, "clkcon_reset");
    wr(5'h07, rv);
    rd(5'h07, rv, "buffer_early");
    rd(5'h1F, 8'h00, "unmapped");
    watch(40);
    see("pin_before_ready", 8'h00, hi[7:0]);
    wait_rdy;
    rd(`STCO_ADDR_STATUS, 8'h01, "ready_set");
    wr(`STCO_ADDR_CTRL1, 8'h0C);
    see("tx_rx", 8'h03, {6'h00, txr, rxe});
    watch(60);
    see("div4", {4'h0, `STCO_PER_4}, p[7:0]);
    for (int i = 0; i < 5; i++) begin
      fork
        wr(`STCO_ADDR_CLKCON, 8'hF8 | {5'h00, CODES[i]});
        watch(220);
      join
      see("gap", 8'h01, {7'h00, lo >= 2 && lo <= 8});
      rd(`STCO_ADDR_CLKCON, {5'h00, CODES[i]}, "clkcon_rb");
      watch(60);
      see("period", {4'h0, PERS[i]}, p[7:0]);
      see("high", {4'h0, HIGHS[i]}, hi[7:0]);
    end
    wr(`STCO_ADDR_CLKCON, 8'h00);
    watch(60);
    see("off", 8'h00, hi[7:0]);
    wr(`STCO_ADDR_CLKCON, 8'h03);
    u_host.xfer(`STCO_OP_SOFT_RESET, 8'hFF);
    rd(`STCO_ADDR_CLKCON, 8'h03, "clkcon_soft");
    see("ready_soft", 8'h01, {7'h00, rdy});
    for (int j = 0; j < 2; j++) begin
      pin_reset(j[0]);
      see("duplex", {7'h00, j[0]}, {7'h00, dpx});
      wb = ~wb;
      ev = 7'($urandom);
      repeat (40) @(posedge clk);
      see("duplex_held", {7'h00, j[0]}, {7'h00, dpx});
      see("led_a", {7'h00, ev[3] ^ wa}, {7'h00, pa});
      see("led_b", {7'h00, ev[1] ^ j[0]}, {7'h00, pb});
      watch(40);
      see("period_pin", 8'h03, p[7:0]);
    end
    rd(`STCO_ADDR_LEDSENSE, {6'h00, 1'b1, wa}, "sensed_sink");
    wr(`STCO_ADDR_LEDCFG_HI, 8'h38);
    see("led_a_on", {7'h00, ~wa}, {7'h00, pa});
    wr(`STCO_ADDR_LEDCFG_HI, 8'h39);
    see("led_a_off", {7'h00, wa}, {7'h00, pa});
    wr(`STCO_ADDR_CTRL1, 8'h01);
    watch(40);
    see("pd_run", 8'h03, p[7:0]);
    see("pd_ready", 8'h03, {6'h00, pd, rdy});
    wr(`STCO_ADDR_CTRL1, 8'h00);
    rd(`STCO_ADDR_STATUS, 8'h00, "ready_restart");
    watch(40);
    see("pd_exit_run", 8'h03, p[7:0]);
    wait_rdy;
    see("ready_again", 8'h01, {7'h00, rdy});
    close_out;
  end
  initial begin
    #(25 * 60000);
    fail_count++;
    close_out;
  end
endmodule
